//--- design/capture_compare_unit.sv
// top: AXI4-Lite register slave around the capture/compare engine
// assumes one clock, synchronous active-high reset, timer count from outside
//
// Contract
// - capture copies full sixteen-bit timer count
// - events: fall, rise, fourth rise, sixteenth rise
// - four-bit mode field selects behaviour
// - capture sets flag; only software clears
// - new capture overwrites unread old value
// - own port writes on pin trigger capture
// - mode change may set spurious flag
// - prescaler cleared when off or not capturing
// - prescale switch keeps counter, partial count
// - compare register equals timer every cycle
// - match drives pin high, low, or keeps
// - flag set same cycle match acts
// - writing zero forces compare latch low
//
// The register offsets and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
module capture_compare_unit
(
	// clock and reset
	input  wire logic        CLOCK_I,
	input  wire logic        RST_I,
	// axi write address
	input  wire logic [7:0]  AWADDR_I,
	input  wire logic        AWVALID_I,
	output logic             AWREADY_O,
	// axi write data
	input  wire logic [31:0] WDATA_I,
	input  wire logic [3:0]  WSTRB_I,
	input  wire logic        WVALID_I,
	output logic             WREADY_O,
	// axi write response
	output logic [1:0]       BRESP_O,
	output logic             BVALID_O,
	input  wire logic        BREADY_I,
	// axi read address
	input  wire logic [7:0]  ARADDR_I,
	input  wire logic        ARVALID_I,
	output logic             ARREADY_O,
	// axi read data
	output logic [31:0]      RDATA_O,
	output logic [1:0]       RRESP_O,
	output logic             RVALID_O,
	input  wire logic        RREADY_I,
	// timer and pin
	input  wire logic [15:0] TIMER_I,
	input  wire logic        PIN_I,
	output logic             CMP_LATCH_O,
	output logic             IRQ_FLAG_O
);

	// ***************************************************************
	// bus slave state
	// ***************************************************************
	typedef struct packed
	{
		logic        aw_held;
		logic [7:0]  aw_addr;
		logic        w_held;
		logic [31:0] w_data;
		logic [3:0]  w_strb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [1:0]  rresp;
		logic [31:0] rdata;
		logic [3:0]  mode;
		logic [15:0] compare;
		logic        irq_enable;
		logic        mode_write;
		logic        flag_clear;
		logic        capture_read;
		logic        cmp_out;
		logic        flag_out;
	} bus_state_t;

	bus_state_t state;
	bus_state_t next_state;

	ccu_regs_if regs ();

	logic [15:0] capture_value;
	logic        core_flag;
	logic        core_latch;

	ccu_core core
	(
		.clk_i       (CLOCK_I),
		.rst_i       (RST_I),
		.regs        (regs.core),
		.timer_i     (TIMER_I),
		.pin_i       (PIN_I),
		.capture_o   (capture_value),
		.flag_o      (core_flag),
		.cmp_latch_o (core_latch)
	);

	assign regs.mode = state.mode;
	assign regs.mode_write = state.mode_write;
	assign regs.compare_value = state.compare;
	assign regs.flag_clear = state.flag_clear;
	assign regs.capture_read = state.capture_read;

	logic        do_write;
	logic        do_read;
	logic [31:0] wd;

	// ***************************************************************
	// next-state logic
	// ***************************************************************
	always_comb
	begin
		next_state = state;
		next_state.mode_write = 1'b0;
		next_state.flag_clear = 1'b0;
		next_state.capture_read = 1'b0;
		next_state.cmp_out = core_latch;
		next_state.flag_out = core_flag;
		wd = state.w_data;
		if (AWVALID_I && !state.aw_held)
		begin
			next_state.aw_held = 1'b1;
			next_state.aw_addr = AWADDR_I;
		end
		if (WVALID_I && !state.w_held)
		begin
			next_state.w_held = 1'b1;
			next_state.w_data = WDATA_I;
			next_state.w_strb = WSTRB_I;
		end
		if (state.bvalid && BREADY_I)
			next_state.bvalid = 1'b0;
		if (state.rvalid && RREADY_I)
			next_state.rvalid = 1'b0;
		// one write resolves per cycle, response must drain first
		do_write = state.aw_held && state.w_held && !state.bvalid;
		do_read = ARVALID_I && !state.rvalid;
		if (do_write)
		begin
			next_state.aw_held = 1'b0;
			next_state.w_held = 1'b0;
			next_state.bvalid = 1'b1;
			next_state.bresp = ccu_pkg::RESP_OKAY;
			case (state.aw_addr)
				ccu_pkg::OFF_UNIT_CONTROL:
				begin
					if (state.w_strb[0])
					begin
						next_state.mode = wd[ccu_pkg::MODE_MSB:
							ccu_pkg::MODE_LSB];
						next_state.mode_write = 1'b1;
					end
				end
				ccu_pkg::OFF_CAPTURE_VALUE:
				begin
					if (state.w_strb[0])
						next_state.compare[7:0] = wd[7:0];
					if (state.w_strb[1])
						next_state.compare[15:8] = wd[15:8];
				end
				ccu_pkg::OFF_FLAG_REG:
				begin
					if (state.w_strb[0] && !wd[ccu_pkg::FLAG_BIT])
						next_state.flag_clear = 1'b1;
				end
				ccu_pkg::OFF_ENABLE_REG:
				begin
					if (state.w_strb[0])
						next_state.irq_enable = wd[ccu_pkg::FLAG_BIT];
				end
				default:
					next_state.bresp = ccu_pkg::RESP_SLVERR;
			endcase
		end
		if (do_read)
		begin
			next_state.rvalid = 1'b1;
			next_state.rresp = ccu_pkg::RESP_OKAY;
			next_state.rdata = ccu_pkg::RESET_WORD;
			case (ARADDR_I)
				ccu_pkg::OFF_UNIT_CONTROL:
					next_state.rdata[3:0] = state.mode;
				ccu_pkg::OFF_CAPTURE_VALUE:
				begin
					// capture and compare share the value register
					if (ccu_pkg::MODE_CMP_HIGH <= state.mode)
						next_state.rdata[15:0] = state.compare;
					else
						next_state.rdata[15:0] = capture_value;
					next_state.capture_read = 1'b1;
				end
				ccu_pkg::OFF_FLAG_REG:
					next_state.rdata[ccu_pkg::FLAG_BIT] = core_flag;
				ccu_pkg::OFF_ENABLE_REG:
					next_state.rdata[ccu_pkg::FLAG_BIT] = state.irq_enable;
				default:
					next_state.rresp = ccu_pkg::RESP_SLVERR;
			endcase
		end
	end

	always_ff @(posedge CLOCK_I)
	begin
		if (RST_I)
			state <= '0;
		else
			state <= next_state;
	end

	// ***************************************************************
	// outputs
	// ***************************************************************
	assign AWREADY_O = ~state.aw_held;
	assign WREADY_O = ~state.w_held;
	assign BVALID_O = state.bvalid;
	assign BRESP_O = state.bresp;
	assign ARREADY_O = ~state.rvalid;
	assign RVALID_O = state.rvalid;
	assign RRESP_O = state.rresp;
	assign RDATA_O = state.rdata;
	assign CMP_LATCH_O = state.cmp_out;
	assign IRQ_FLAG_O = state.flag_out;

endmodule

//--- design/ccu_pkg.sv
// package: register map, mode codes and field layout of the capture/compare unit
// assumes a 32-bit AXI4-Lite register bus and a 16-bit timer count input
package ccu_pkg;

	// ***************************************************************
	// register offsets (byte addresses)
	// ***************************************************************
	localparam logic [7:0] OFF_UNIT_CONTROL     = 8'h00;
	localparam logic [7:0] OFF_CAPTURE_VALUE    = 8'h04;
	localparam logic [7:0] OFF_FLAG_REG         = 8'h08;
	localparam logic [7:0] OFF_ENABLE_REG       = 8'h0C;

	// ***************************************************************
	// field positions
	// ***************************************************************
	localparam int MODE_LSB  = 0;
	localparam int MODE_MSB  = 3;
	localparam int FLAG_BIT  = 2;
	localparam int ADDR_MSB  = 7;

	// ***************************************************************
	// mode codes
	// ***************************************************************
	localparam logic [3:0] MODE_OFF        = 4'h0;
	localparam logic [3:0] MODE_CAP_FALL   = 4'h4;
	localparam logic [3:0] MODE_CAP_RISE   = 4'h5;
	localparam logic [3:0] MODE_CAP_RISE4  = 4'h6;
	localparam logic [3:0] MODE_CAP_RISE16 = 4'h7;
	localparam logic [3:0] MODE_CMP_HIGH   = 4'h8;
	localparam logic [3:0] MODE_CMP_LOW    = 4'h9;
	localparam logic [3:0] MODE_CMP_KEEP   = 4'hA;

	// ***************************************************************
	// reset values and counts
	// ***************************************************************
	localparam logic [3:0]  PRESCALE_4_LAST  = 4'h3;
	localparam logic [3:0]  PRESCALE_16_LAST = 4'hF;
	localparam logic [31:0] RESET_WORD       = 32'h0000_0000;
	localparam logic [1:0]  RESP_OKAY        = 2'h0;
	localparam logic [1:0]  RESP_SLVERR      = 2'h2;

endpackage

//--- design/ccu_regs_if.sv
// interface: register values handed from the bus slave to the unit core
// assumes both ends share the unit's single clock
`timescale 1ns/1ps
interface ccu_regs_if;
	logic [3:0]  mode;
	logic        mode_write;
	logic [15:0] compare_value;
	logic        flag_clear;
	logic        capture_read;

	modport slave
	(
		output mode,
		output mode_write,
		output compare_value,
		output flag_clear,
		output capture_read
	);
	modport core
	(
		input  mode,
		input  mode_write,
		input  compare_value,
		input  flag_clear,
		input  capture_read
	);
endinterface

//--- design/ccu_core.sv
// capture/compare engine: edge detect, prescaler, capture latch, compare output
// assumes the timer count is stable; the pin input passes a two-flop sync here first
`timescale 1ns/1ps
module ccu_core
(
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// register side
	ccu_regs_if.core         regs,
	// timer and pin
	input  wire logic [15:0] timer_i,
	input  wire logic        pin_i,
	// results
	output logic [15:0]      capture_o,
	output logic             flag_o,
	output logic             cmp_latch_o
);

	typedef struct packed
	{
		logic        sync1;
		logic        sync2;
		logic        pin_prev;
		logic [3:0]  prescale;
		logic [15:0] capture;
		logic        flag;
		logic        cmp_latch;
		logic        unread;
	} core_state_t;

	core_state_t state;
	core_state_t next_state;

	function automatic logic is_capture(input logic [3:0] m);
		is_capture = (m == ccu_pkg::MODE_CAP_FALL) ||
			(m == ccu_pkg::MODE_CAP_RISE) ||
			(m == ccu_pkg::MODE_CAP_RISE4) ||
			(m == ccu_pkg::MODE_CAP_RISE16);
	endfunction

	function automatic logic is_compare(input logic [3:0] m);
		is_compare = (m == ccu_pkg::MODE_CMP_HIGH) ||
			(m == ccu_pkg::MODE_CMP_LOW) ||
			(m == ccu_pkg::MODE_CMP_KEEP);
	endfunction

	logic rise;
	logic fall;
	logic event_hit;
	logic match;

	always_comb
	begin
		next_state = state;
		rise = state.sync2 & ~state.pin_prev;
		fall = ~state.sync2 & state.pin_prev;
		event_hit = 1'b0;
		match = 1'b0;
		next_state.sync1 = pin_i;
		next_state.sync2 = state.sync1;
		next_state.pin_prev = state.sync2;
		if (regs.capture_read)
			next_state.unread = 1'b0;
		if (regs.flag_clear)
			next_state.flag = 1'b0;
		// prescaler kept while hopping between capture codes
		if (!is_capture(regs.mode))
			next_state.prescale = 4'h0;
		case (regs.mode)
			ccu_pkg::MODE_CAP_FALL:
				event_hit = fall;
			ccu_pkg::MODE_CAP_RISE:
				event_hit = rise;
			ccu_pkg::MODE_CAP_RISE4:
			begin
				if (rise)
				begin
					event_hit = (state.prescale >=
						ccu_pkg::PRESCALE_4_LAST);
					next_state.prescale = event_hit ? 4'h0 :
						state.prescale + 4'h1;
				end
			end
			ccu_pkg::MODE_CAP_RISE16:
			begin
				if (rise)
				begin
					event_hit = (state.prescale ==
						ccu_pkg::PRESCALE_16_LAST);
					next_state.prescale = state.prescale + 4'h1;
				end
			end
			ccu_pkg::MODE_CMP_HIGH,
			ccu_pkg::MODE_CMP_LOW,
			ccu_pkg::MODE_CMP_KEEP:
				match = (timer_i == regs.compare_value);
			default:
				event_hit = 1'b0;
		endcase
		// pin fed back from the pad, so port writes also capture
		if (event_hit)
		begin
			next_state.capture = timer_i;
			next_state.unread = 1'b1;
			next_state.flag = 1'b1;
		end
		if (match)
		begin
			next_state.flag = 1'b1;
			if (regs.mode == ccu_pkg::MODE_CMP_HIGH)
				next_state.cmp_latch = 1'b1;
			else if (regs.mode == ccu_pkg::MODE_CMP_LOW)
				next_state.cmp_latch = 1'b0;
		end
		// mode hops can glitch the flag; software masks and clears
		if (regs.mode_write && regs.mode == ccu_pkg::MODE_OFF)
			next_state.cmp_latch = 1'b0;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			state <= '0;
		else
			state <= next_state;
	end

	assign capture_o = state.capture;
	assign flag_o = state.flag;
	assign cmp_latch_o = state.cmp_latch;

endmodule

//--- bench/ccu_monitor.sv
// checker: bus handshakes and capture/compare timing at the unit's ports
// assumes the bench offers write address and data in the same cycle
`timescale 1ns/1ps
module ccu_monitor
(
	// clock and reset
	input  wire logic        CLOCK_I,
	input  wire logic        RST_I,
	// register bus
	input  wire logic [7:0]  AWADDR_I,
	input  wire logic        AWVALID_I,
	input  wire logic        AWREADY_O,
	input  wire logic [31:0] WDATA_I,
	input  wire logic        WVALID_I,
	input  wire logic        WREADY_O,
	input  wire logic        BVALID_O,
	input  wire logic        ARVALID_I,
	input  wire logic        ARREADY_O,
	input  wire logic        RVALID_O,
	input  wire logic        RREADY_I,
	// timer and pin
	input  wire logic [15:0] TIMER_I,
	input  wire logic        PIN_I,
	input  wire logic        CMP_LATCH_O,
	input  wire logic        IRQ_FLAG_O
);
	logic [3:0]  mode;
	logic [15:0] cmp;
	logic        ctl_wr;
	logic        wr_go;
	logic        hit;
	assign wr_go = AWVALID_I && AWREADY_O && WVALID_I && WREADY_O;
	assign hit   = TIMER_I == cmp;
	// shadow copy; misses writes whose halves are taken apart
	always_ff @(posedge CLOCK_I)
	begin
		if (RST_I)
		begin
			mode   <= ccu_pkg::MODE_OFF;
			cmp    <= 16'h0000;
			ctl_wr <= 1'b0;
		end
		else if (wr_go)
		begin
			ctl_wr <= AWADDR_I == ccu_pkg::OFF_UNIT_CONTROL;
			if (AWADDR_I == ccu_pkg::OFF_UNIT_CONTROL)
				mode <= WDATA_I[3:0];
			if (AWADDR_I == ccu_pkg::OFF_CAPTURE_VALUE)
				cmp <= WDATA_I[15:0];
		end
	end
	default clocking dc @(posedge CLOCK_I); endclocking
	default disable iff (RST_I);
	// response flop sets one edge after both halves are held
	a_write_answer: assert property
		(wr_go |-> ##2 BVALID_O) else $error("write not answered");
	a_read_answer: assert property
		(ARVALID_I && ARREADY_O && RREADY_I |=> RVALID_O ##1 !RVALID_O)
		else $error("read answer missing or stuck");
	a_read_ready: assert property
		(ARREADY_O == !RVALID_O) else $error("read ready wrong");
	a_flag_sw_clear: assert property
		($fell(IRQ_FLAG_O) |-> $past(BVALID_O) || $past(BVALID_O, 2))
		else $error("flag cleared without a write");
	a_capture_flag: assert property
		(mode == ccu_pkg::MODE_CAP_RISE && $rose(PIN_I) |-> ##[2:8] IRQ_FLAG_O)
		else $error("rising edge did not set flag");
	a_match_high: assert property
		(mode == ccu_pkg::MODE_CMP_HIGH && hit
			|-> ##[2:3] (CMP_LATCH_O && IRQ_FLAG_O))
		else $error("match did not drive high");
	a_match_low: assert property
		(mode == ccu_pkg::MODE_CMP_LOW && hit |-> ##[2:3] !CMP_LATCH_O)
		else $error("match did not drive low");
	a_match_keep: assert property
		(mode == ccu_pkg::MODE_CMP_KEEP && hit
			|-> ##1 $stable(CMP_LATCH_O)[*3])
		else $error("keep match changed output");
	a_same_cycle: assert property
		($rose(CMP_LATCH_O) |-> IRQ_FLAG_O)
		else $error("latch rose without flag");
	a_off_low: assert property
		($rose(BVALID_O) && ctl_wr && mode == ccu_pkg::MODE_OFF
			|-> ##[1:4] !CMP_LATCH_O)
		else $error("off did not clear latch");
	cover property (mode == ccu_pkg::MODE_CMP_HIGH && hit);
	cover property ($rose(IRQ_FLAG_O));
	cover property (RVALID_O && RREADY_I);
endmodule
bind capture_compare_unit ccu_monitor mon
(
	.CLOCK_I(CLOCK_I), .RST_I(RST_I), .AWADDR_I(AWADDR_I),
	.AWVALID_I(AWVALID_I), .AWREADY_O(AWREADY_O), .WDATA_I(WDATA_I),
	.WVALID_I(WVALID_I), .WREADY_O(WREADY_O), .BVALID_O(BVALID_O),
	.ARVALID_I(ARVALID_I), .ARREADY_O(ARREADY_O), .RVALID_O(RVALID_O),
	.RREADY_I(RREADY_I), .TIMER_I(TIMER_I), .PIN_I(PIN_I),
	.CMP_LATCH_O(CMP_LATCH_O), .IRQ_FLAG_O(IRQ_FLAG_O)
);

//--- bench/ccu_pin_src.sv
// pin model: outside driver or load on the capture/compare pin
// assumes the bench calls level() from its main thread
`timescale 1ns/1ps
module ccu_pin_src
(
	// clock
	input  wire logic clk_i,
	// unit side
	input  wire logic drive_i,
	input  wire logic latch_i,
	// pad
	output logic      pin_o
);
	logic lvl;
	initial lvl = 1'b0;
	// pad follows the unit's latch while the pin is an output
	assign pin_o = drive_i ? latch_i : lvl;
	// hold long enough for the two-flop sync and edge register
	task automatic level(input logic v);
		@(posedge clk_i);
		lvl <= v;
		repeat (8) @(posedge clk_i);
	endtask
endmodule

//--- bench/tb.sv
// testbench: bus tasks plus capture and compare sequences
// assumes the pin model and the bound checker are compiled first
`timescale 1ns/1ps
module tb;
	// ************
	// signals
	// ************
	logic        clk, rst, awvalid, wvalid, bready, arvalid, rready, drv;
	logic        awready, wready, bvalid, arready, rvalid, latch, flag, pin;
	logic        act;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb, m;
	logic [1:0]  bresp, rresp;
	logic [15:0] timer;
	int          bad_count, checks_done, cycles, n;
	logic [3:0]  cap_mode [4] = '{ccu_pkg::MODE_CAP_FALL,
		ccu_pkg::MODE_CAP_RISE, ccu_pkg::MODE_CAP_RISE4,
		ccu_pkg::MODE_CAP_RISE16};
	int          cap_n [4] = '{1, 1, 4, 16};
	logic [3:0]  cmp_mode [5] = '{ccu_pkg::MODE_CMP_HIGH,
		ccu_pkg::MODE_CMP_KEEP, ccu_pkg::MODE_CMP_LOW,
		ccu_pkg::MODE_CMP_KEEP, ccu_pkg::MODE_CMP_HIGH};
	logic        cmp_exp [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
	capture_compare_unit dut
	(
		.CLOCK_I(clk), .RST_I(rst), .AWADDR_I(awaddr), .AWVALID_I(awvalid),
		.AWREADY_O(awready), .WDATA_I(wdata), .WSTRB_I(wstrb),
		.WVALID_I(wvalid), .WREADY_O(wready), .BRESP_O(bresp),
		.BVALID_O(bvalid), .BREADY_I(bready), .ARADDR_I(araddr),
		.ARVALID_I(arvalid), .ARREADY_O(arready), .RDATA_O(rdata),
		.RRESP_O(rresp), .RVALID_O(rvalid), .RREADY_I(rready),
		.TIMER_I(timer), .PIN_I(pin), .CMP_LATCH_O(latch),
		.IRQ_FLAG_O(flag)
	);
	ccu_pin_src src (.clk_i(clk), .drive_i(drv), .latch_i(latch),
		.pin_o(pin));
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// ************
	// tasks
	// ************
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			bad_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] r);
		@(posedge clk);
		awaddr  <= a;
		wdata   <= d;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		fork
			begin
				do @(posedge clk); while (awready !== 1'b1);
				awvalid <= 1'b0;
			end
			begin
				do @(posedge clk); while (wready !== 1'b1);
				wvalid <= 1'b0;
			end
		join
		do @(posedge clk); while (bvalid !== 1'b1);
		bready <= 1'b0;
		chk({30'h0, bresp}, {30'h0, r});
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] r);
		@(posedge clk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do @(posedge clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge clk); while (rvalid !== 1'b1);
		rready <= 1'b0;
		chk({30'h0, rresp}, {30'h0, r});
		if (r == ccu_pkg::RESP_OKAY)
			chk(rdata, d);
	endtask
	// timer held steady across each pin edge
	task automatic pulse(input logic [15:0] t);
		@(posedge clk);
		timer <= t;
		src.level(act);
		src.level(!act);
	endtask
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			bad_count++;
			wrap_up();
		end
	end
	// ************
	// sequence
	// ************
	initial
	begin
		{rst, awvalid, wvalid, bready, arvalid, rready, drv} = 7'h40;
		{awaddr, araddr, wdata, timer} = '0;
		wstrb = 4'hF;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		rd(ccu_pkg::OFF_UNIT_CONTROL, ccu_pkg::RESET_WORD, 2'h0);
		rd(ccu_pkg::OFF_FLAG_REG, ccu_pkg::RESET_WORD, 2'h0);
		wr(ccu_pkg::OFF_ENABLE_REG, 32'h4, 2'h0);
		rd(ccu_pkg::OFF_ENABLE_REG, 32'h4, 2'h0);
		wr(ccu_pkg::OFF_ENABLE_REG, 32'h0, 2'h0);
		wr(8'h10, 32'h0, ccu_pkg::RESP_SLVERR);
		rd(8'h10, 32'h0, ccu_pkg::RESP_SLVERR);
		for (int i = 0; i < 4; i++)
		begin
			m = cap_mode[i];
			n = cap_n[i];
			act = m != ccu_pkg::MODE_CAP_FALL;
			src.level(!act);
			wr(ccu_pkg::OFF_UNIT_CONTROL, {28'h0, m}, 2'h0);
			pulse(16'h0000);
			wr(ccu_pkg::OFF_UNIT_CONTROL, 32'h0, 2'h0);
			wr(ccu_pkg::OFF_UNIT_CONTROL, {28'h0, m}, 2'h0);
			wr(ccu_pkg::OFF_FLAG_REG, 32'h0, 2'h0);
			for (int j = 1; j <= 2 * n; j++)
			begin
				pulse({m, 12'h000} + 16'(j));
				if (j == n - 1)
					rd(ccu_pkg::OFF_FLAG_REG, 32'h0, 2'h0);
			end
			rd(ccu_pkg::OFF_FLAG_REG, 32'h4, 2'h0);
			rd(ccu_pkg::OFF_CAPTURE_VALUE, {16'h0, m, 12'h0} + 32'(2 * n),
				2'h0);
			wr(ccu_pkg::OFF_FLAG_REG, 32'h0, 2'h0);
			rd(ccu_pkg::OFF_FLAG_REG, 32'h0, 2'h0);
		end
		wr(ccu_pkg::OFF_UNIT_CONTROL, 32'h0, 2'h0);
		@(posedge clk);
		drv <= 1'b1;
		wr(ccu_pkg::OFF_CAPTURE_VALUE, 32'h5A5A, 2'h0);
		for (int i = 0; i < 5; i++)
		begin
			wr(ccu_pkg::OFF_UNIT_CONTROL, {28'h0, cmp_mode[i]}, 2'h0);
			wr(ccu_pkg::OFF_FLAG_REG, 32'h0, 2'h0);
			rd(ccu_pkg::OFF_CAPTURE_VALUE, 32'h5A5A, 2'h0);
			@(posedge clk);
			timer <= 16'h5A5A;
			@(posedge clk);
			timer <= 16'h0001;
			repeat (4) @(posedge clk);
			chk({31'h0, latch}, {31'h0, cmp_exp[i]});
			rd(ccu_pkg::OFF_FLAG_REG, 32'h4, 2'h0);
		end
		wr(ccu_pkg::OFF_UNIT_CONTROL, 32'h0, 2'h0);
		repeat (4) @(posedge clk);
		chk({31'h0, latch}, 32'h0);
		wrap_up();
	end
endmodule
